// ---- verilog/hbp_host_byte_port.sv ----
// slave end of the asynchronous byte-wide host port with its four access registers
// assumes the host pins are asynchronous; internal register space answers reads with an ack
`timescale 1ns/100ps
module hbp_host_byte_port (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic host_chip_select_n,
   input wire logic read_not_write,
   input wire logic [hbp_pkg::SEL_W-1:0] access_reg_select,
   input wire logic [hbp_pkg::BYTE_W-1:0] host_data_in,
   output logic [hbp_pkg::BYTE_W-1:0] host_data_out,
   output logic host_data_oe_n,
   output logic host_ready_n,
   output logic host_ready_oe_n,
   output logic [hbp_pkg::ADDR_W-1:0] indirect_address,
   output logic [hbp_pkg::BYTE_W-1:0] internal_wdata,
   output logic internal_wr,
   output logic internal_rd,
   input wire logic [hbp_pkg::BYTE_W-1:0] internal_rdata,
   input wire logic internal_rd_ack,
   output logic hard_reset_req
);
   hbp_pkg::hbp_state_type state;
   hbp_pkg::hbp_state_type next_state;
   logic cs_meta;
   logic cs_sync;
   logic cs_last;
   logic rnw_meta;
   logic rnw_sync;
   logic [hbp_pkg::SEL_W-1:0] sel_meta;
   logic [hbp_pkg::SEL_W-1:0] sel_sync;
   logic [hbp_pkg::BYTE_W-1:0] din_meta;
   logic [hbp_pkg::BYTE_W-1:0] din_sync;
   logic rd_cycle;
   logic [hbp_pkg::SEL_W-1:0] cyc_sel;
   logic start;
   logic in_access;
   logic wr_now;
   logic rd_now;
   logic sel_is_data;
   logic next_ready_n;
   logic next_ready_oe_n;
   logic next_data_oe_n;
   logic next_internal_wr;
   logic next_internal_rd;
   logic next_hard_reset;
   logic [hbp_pkg::BYTE_W-1:0] next_data_out;

   hbp_addr_if abus ();

   hbp_addr_reg u_addr (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .bus(abus.regs)
   );

   // every host pin passes two flops; chip select passes a third for edge detection, and the first stage is never read
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         cs_last <= 1'b1;
         rnw_meta <= 1'b1;
         rnw_sync <= 1'b1;
         sel_meta <= hbp_pkg::SEL_ADDR_LOW;
         sel_sync <= hbp_pkg::SEL_ADDR_LOW;
         din_meta <= hbp_pkg::BYTE_RESET;
         din_sync <= hbp_pkg::BYTE_RESET;
      end else if (ce) begin
         cs_meta <= host_chip_select_n;
         cs_sync <= cs_meta;
         cs_last <= cs_sync;
         rnw_meta <= read_not_write;
         rnw_sync <= rnw_meta;
         sel_meta <= access_reg_select;
         sel_sync <= sel_meta;
         din_meta <= host_data_in;
         din_sync <= din_meta;
      end
   end

   // a new access needs a fresh falling edge of our own chip select
   assign start = !cs_sync && cs_last;
   assign in_access = (state == hbp_pkg::ST_ACCESS);
   // host holds the pins until ready, so the synced copies are settled here
   assign wr_now = in_access && !rnw_sync;
   assign rd_now = in_access && rnw_sync;
   assign sel_is_data = sel_sync[hbp_pkg::SEL_DATA_BIT];

   // transfer sequencing
   always_comb begin
      next_state = state;
      case (state)
         hbp_pkg::ST_IDLE: begin
            if (start) begin
               next_state = hbp_pkg::ST_ACCESS;
            end
         end
         hbp_pkg::ST_ACCESS: begin
            next_state = (rnw_sync && sel_is_data) ? hbp_pkg::ST_RDWAIT : hbp_pkg::ST_ACK;
         end
         hbp_pkg::ST_RDWAIT: begin
            // a host that gives up early still gets a clean release
            if (cs_sync) begin
               next_state = hbp_pkg::ST_RELEASE;
            end else if (internal_rd_ack) begin
               next_state = hbp_pkg::ST_ACK;
            end
         end
         hbp_pkg::ST_ACK: begin
            if (cs_sync) begin
               next_state = hbp_pkg::ST_RELEASE;
            end
         end
         hbp_pkg::ST_RELEASE: begin
            next_state = hbp_pkg::ST_IDLE;
         end
         default: begin
            next_state = hbp_pkg::ST_IDLE;
         end
      endcase
   end

   // access register decode
   assign abus.wr_low = wr_now && (sel_sync == hbp_pkg::SEL_ADDR_LOW);
   assign abus.wr_high = wr_now && (sel_sync == hbp_pkg::SEL_ADDR_HIGH);
   assign abus.wdata = din_sync;
   assign abus.inc = (state == hbp_pkg::ST_RELEASE) && (cyc_sel == hbp_pkg::SEL_DATA_INC);
   assign indirect_address = abus.addr;
   assign next_internal_wr = wr_now && sel_is_data;
   assign next_internal_rd = rd_now && sel_is_data;
   assign next_hard_reset = abus.wr_high && (din_sync == hbp_pkg::HARD_RESET_CODE);
   assign next_data_out = (rd_now && sel_sync == hbp_pkg::SEL_ADDR_LOW) ?
                             abus.addr[hbp_pkg::BYTE_W-1:0] :
                          (rd_now && sel_sync == hbp_pkg::SEL_ADDR_HIGH) ?
                             abus.addr[hbp_pkg::ADDR_W-1:hbp_pkg::BYTE_W] :
                          (state == hbp_pkg::ST_RDWAIT && internal_rd_ack) ? internal_rdata :
                          host_data_out;
   // direction of the current cycle; operands passed in so callers re-evaluate on change
   function automatic logic rd_cycle_next(input logic acc, input logic rnw, input logic held);
      rd_cycle_next = acc ? rnw : held;
   endfunction

   // pins follow next_state so ready and data appear together
   assign next_ready_n = (next_state != hbp_pkg::ST_ACK);
   assign next_ready_oe_n = !(next_state == hbp_pkg::ST_ACK ||
                              next_state == hbp_pkg::ST_RELEASE);
   assign next_data_oe_n = !(next_state == hbp_pkg::ST_ACK &&
                             rd_cycle_next(in_access, rnw_sync, rd_cycle));

   // state and cycle bookkeeping
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= hbp_pkg::ST_IDLE;
         rd_cycle <= 1'b0;
         cyc_sel <= hbp_pkg::SEL_ADDR_LOW;
      end else if (ce) begin
         state <= next_state;
         rd_cycle <= rd_cycle_next(in_access, rnw_sync, rd_cycle);
         cyc_sel <= in_access ? sel_sync : cyc_sel;
      end
   end

   // registered pin and strobe outputs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         host_ready_n <= 1'b1;
         host_ready_oe_n <= 1'b1;
         host_data_oe_n <= 1'b1;
         host_data_out <= hbp_pkg::BYTE_RESET;
         internal_wr <= 1'b0;
         internal_rd <= 1'b0;
         internal_wdata <= hbp_pkg::BYTE_RESET;
         hard_reset_req <= 1'b0;
      end else if (ce) begin
         host_ready_n <= next_ready_n;
         host_ready_oe_n <= next_ready_oe_n;
         host_data_oe_n <= next_data_oe_n;
         host_data_out <= next_data_out;
         internal_wr <= next_internal_wr;
         internal_rd <= next_internal_rd;
         internal_wdata <= wr_now ? din_sync : internal_wdata;
         hard_reset_req <= next_hard_reset;
      end
   end

   start_edge_a: assert property (@(posedge clk) disable iff (!resetn || !ce)
      state == hbp_pkg::ST_ACCESS |-> !$past(cs_sync) && $past(cs_last))
      else $error("access began without a synced chip select fall");
   write_ack_a: assert property (@(posedge clk) disable iff (!resetn || !ce)
      wr_now |=> !host_ready_n && !host_ready_oe_n)
      else $error("write not acknowledged the next cycle");
   ready_release_a: assert property (@(posedge clk) disable iff (!resetn || !ce)
      !host_ready_n && cs_sync && state == hbp_pkg::ST_ACK
         |=> host_ready_n && !host_ready_oe_n ##1 host_ready_oe_n)
      else $error("ready not high for exactly one cycle before float");
   read_drive_a: assert property (@(posedge clk) disable iff (!resetn || !ce)
      !host_ready_n && rd_cycle |-> !host_data_oe_n)
      else $error("read acknowledged without driving data");
   data_float_a: assert property (@(posedge clk) disable iff (!resetn || !ce)
      host_ready_n |-> host_data_oe_n)
      else $error("data bus driven outside acknowledge");
   read_fetch_a: assert property (@(posedge clk) disable iff (!resetn || !ce)
      rd_now && sel_is_data |=> internal_rd ##1 !internal_rd)
      else $error("internal read strobe wrong");
   reset_code_a: assert property (@(posedge clk) disable iff (!resetn || !ce)
      wr_now && sel_sync == hbp_pkg::SEL_ADDR_HIGH && din_sync == hbp_pkg::HARD_RESET_CODE
         |=> hard_reset_req)
      else $error("reset code did not request hardware reset");
   no_restart_a: assert property (@(posedge clk) disable iff (!resetn || !ce)
      state == hbp_pkg::ST_IDLE && !cs_sync && !cs_last |=> state == hbp_pkg::ST_IDLE)
      else $error("access restarted while chip select stayed low");
   ready_hold_a: assert property (@(posedge clk) disable iff (!resetn || !ce)
      state == hbp_pkg::ST_ACK && !cs_sync |=> !host_ready_n)
      else $error("ready dropped while chip select still low");
   ready_float_a: assert property (@(posedge clk) disable iff (!resetn || !ce)
      state == hbp_pkg::ST_IDLE |-> host_ready_oe_n && host_data_oe_n)
      else $error("ready or data driven while idle");
   abort_release_a: assert property (@(posedge clk) disable iff (!resetn || !ce)
      state == hbp_pkg::ST_RDWAIT && cs_sync
         |=> host_ready_n && !host_ready_oe_n && host_data_oe_n ##1 host_ready_oe_n)
      else $error("abandoned read not released cleanly");
endmodule

// ---- verilog/hbp_pkg.sv ----
// constants, codes and state encoding for the host byte port slave
// assumes a single 200 MHz device clock; host pins arrive asynchronously
package hbp_pkg;
   localparam int ADDR_W = 16;
   localparam int BYTE_W = 8;
   localparam int SEL_W = 2;
   localparam logic [SEL_W-1:0] SEL_ADDR_LOW = 2'h0;
   localparam logic [SEL_W-1:0] SEL_ADDR_HIGH = 2'h1;
   localparam logic [SEL_W-1:0] SEL_DATA = 2'h2;
   localparam logic [SEL_W-1:0] SEL_DATA_INC = 2'h3;
   localparam int SEL_DATA_BIT = 1;
   localparam logic [BYTE_W-1:0] HARD_RESET_CODE = 8'h40;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0001;
   localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ACCESS = 3'b001,
      ST_RDWAIT = 3'b010,
      ST_ACK = 3'b011,
      ST_RELEASE = 3'b100
   } hbp_state_type;
endpackage

// ---- verilog/hbp_addr_if.sv ----
// carrier between the port control and the indirect address register
// assumes both ends run on the same device clock
`timescale 1ns/100ps
interface hbp_addr_if;
   logic wr_low;
   logic wr_high;
   logic inc;
   logic [hbp_pkg::BYTE_W-1:0] wdata;
   logic [hbp_pkg::ADDR_W-1:0] addr;
   modport ctrl (output wr_low, output wr_high, output inc, output wdata, input addr);
   modport regs (input wr_low, input wr_high, input inc, input wdata, output addr);
endinterface

// ---- verilog/hbp_addr_reg.sv ----
// the 16-bit indirect address register with byte writes and post-increment
// assumes strobes are one-cycle pulses from the port control, never two at once
`timescale 1ns/100ps
module hbp_addr_reg (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   hbp_addr_if.regs bus
);
   logic [hbp_pkg::ADDR_W-1:0] addr;
   logic [hbp_pkg::ADDR_W-1:0] next_addr;

   // byte lanes write alone so the other half keeps its value
   assign next_addr = bus.wr_low ? {addr[hbp_pkg::ADDR_W-1:hbp_pkg::BYTE_W], bus.wdata} :
                      bus.wr_high ? {bus.wdata, addr[hbp_pkg::BYTE_W-1:0]} :
                      bus.inc ? hbp_pkg::ADDR_W'(addr + hbp_pkg::ADDR_STEP) :
                      addr;
   assign bus.addr = addr;

   // register itself
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         addr <= hbp_pkg::ADDR_RESET;
      end else if (ce) begin
         addr <= next_addr;
      end
   end

   inc_step_a: assert property (@(posedge clk) disable iff (!resetn || !ce)
      bus.inc |=> addr == hbp_pkg::ADDR_W'($past(addr) + hbp_pkg::ADDR_STEP))
      else $error("auto-increment did not add one");
   addr_hold_a: assert property (@(posedge clk) disable iff (!resetn || !ce)
      !bus.wr_low && !bus.wr_high && !bus.inc |=> $stable(addr))
      else $error("indirect address changed without a strobe");
   high_byte_a: assert property (@(posedge clk) disable iff (!resetn || !ce)
      bus.wr_high |=> addr[hbp_pkg::ADDR_W-1:hbp_pkg::BYTE_W] == $past(bus.wdata)
                  && addr[hbp_pkg::BYTE_W-1:0] == $past(addr[hbp_pkg::BYTE_W-1:0]))
      else $error("high byte write disturbed the address");
endmodule

// ---- tb/hbp_regspace_model.sv ----
// behavioural model of the internal register space behind the host byte port
// assumes strobes from the port are one-cycle pulses on the device clock
`timescale 1ns/100ps
module hbp_regspace_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic internal_wr,
   input wire logic internal_rd,
   input wire logic [15:0] indirect_address,
   input wire logic [7:0] internal_wdata,
   output logic [7:0] internal_rdata,
   output logic internal_rd_ack
);
   logic [7:0] mem [0:255];
   logic [1:0] wait_cnt;
   logic pend;
   // slow answer: ack four cycles late; rdata toggles outside ack so stale data never matches
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pend <= 1'b0;
         wait_cnt <= 2'h0;
         internal_rd_ack <= 1'b0;
         internal_rdata <= 8'hFF;
      end else begin
         internal_rd_ack <= 1'b0;
         internal_rdata <= ~internal_rdata;
         if (internal_wr) begin
            mem[indirect_address[7:0]] <= internal_wdata;
         end
         if (internal_rd) begin
            pend <= 1'b1;
            wait_cnt <= 2'h3;
         end else if (pend && wait_cnt == 2'h0) begin
            pend <= 1'b0;
            internal_rd_ack <= 1'b1;
            internal_rdata <= mem[indirect_address[7:0]];
         end else if (pend) begin
            wait_cnt <= wait_cnt - 2'h1;
         end
      end
   end
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the host byte port slave
// assumes the register-space model answers internal reads
`timescale 1ns/100ps
module tb;
   logic clk, resetn, cs_n, rnw, data_oe_n, rdy_n, rdy_oe_n, iwr, ird, ack, hrst;
   logic [1:0] sel;
   logic [7:0] hd_drv, data_out, wdata, rdata, rd_val;
   logic [15:0] addr;
   wire [7:0] bus = data_oe_n ? hd_drv : data_out;
   int n_errors = 0, samples_checked = 0, cycles = 0, n_wr = 0, n_rst = 0, n;
   hbp_host_byte_port dut (.clk(clk), .resetn(resetn), .ce(1'b1), .host_chip_select_n(cs_n),
      .read_not_write(rnw), .access_reg_select(sel), .host_data_in(bus),
      .host_data_out(data_out), .host_data_oe_n(data_oe_n), .host_ready_n(rdy_n),
      .host_ready_oe_n(rdy_oe_n), .indirect_address(addr), .internal_wdata(wdata),
      .internal_wr(iwr), .internal_rd(ird), .internal_rdata(rdata),
      .internal_rd_ack(ack), .hard_reset_req(hrst));
   hbp_regspace_model model (.clk(clk), .resetn(resetn), .internal_wr(iwr),
      .internal_rd(ird), .indirect_address(addr), .internal_wdata(wdata),
      .internal_rdata(rdata), .internal_rd_ack(ack));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // pulse counters and hang guard
   always @(posedge clk) begin
      cycles++;
      if (iwr === 1'b1) n_wr++;
      if (hrst === 1'b1) n_rst++;
      if (cycles == 20000) begin
         n_errors++;
         conclude();
      end
   end
   task check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task conclude;
      $display("checked %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task tick;
      @(posedge clk);
      #1;
   endtask
   // one host cycle; pins settle before cs falls, held until ready, cs kept low hold cycles
   task access(input logic r, input logic [1:0] s, input logic [7:0] d, input int hold);
      int k;
      rnw = r;
      sel = s;
      hd_drv = d;
      repeat (4) tick();
      cs_n = 1'b0;
      k = 0;
      while (rdy_n !== 1'b0 && k < 50) begin
         tick();
         k++;
      end
      check(rdy_n, 16'h0);
      check(rdy_oe_n, 16'h0);
      check(data_oe_n, {15'h0, ~r});
      rd_val = bus;
      repeat (hold) tick();
      check(rdy_n, 16'h0);
      cs_n = 1'b1; // released only after ack
      hd_drv = ~d;
      sel = ~s;
      rnw = ~r;
      k = 0;
      while (rdy_n !== 1'b1 && k < 10) begin
         tick();
         k++;
      end
      check(rdy_n, 16'h1);
      check(rdy_oe_n, 16'h0);
      check(data_oe_n, 16'h1);
      tick();
      check(rdy_oe_n, 16'h1);
   endtask
   task t_addr;
      access(1'b0, 2'h1, 8'h12, 0);
      access(1'b0, 2'h0, 8'h34, 0);
      check(addr, 16'h1234);
      access(1'b1, 2'h1, 8'h00, 0);
      check(rd_val, 16'h12);
      access(1'b1, 2'h0, 8'h00, 0);
      check(rd_val, 16'h34);
   endtask
   task t_data;
      access(1'b0, 2'h2, 8'hA5, 0);
      check(addr, 16'h1234);
      access(1'b1, 2'h2, 8'h00, 0);
      check(rd_val, 16'hA5);
   endtask
   task t_inc;
      access(1'b0, 2'h3, 8'h5A, 0);
      access(1'b0, 2'h3, 8'hC3, 0);
      check(addr, 16'h1236);
      access(1'b0, 2'h0, 8'h34, 0);
      access(1'b1, 2'h3, 8'h00, 0);
      check(rd_val, 16'h5A);
      access(1'b1, 2'h3, 8'h00, 0);
      check(rd_val, 16'hC3);
      check(addr, 16'h1236);
   endtask
   task t_hold;
      n = n_wr;
      access(1'b0, 2'h2, 8'h77, 20);
      check(16'(n_wr - n), 16'h1);
   endtask
   // traffic meant for the companion chip: our select stays high
   task t_other;
      n = n_wr;
      rnw = 1'b0;
      sel = 2'h2;
      hd_drv = 8'h3C;
      repeat (12) tick();
      check(rdy_oe_n, 16'h1);
      check(16'(n_wr - n), 16'h0);
   endtask
   task t_hard;
      n = n_rst;
      access(1'b0, 2'h1, 8'h40, 0);
      check(16'(n_rst - n), 16'h1);
      check(addr[15:8], 16'h40);
   endtask
   // host gives up on a slow read before the answer; the port must still release
   task t_abort;
      rnw = 1'b1;
      sel = 2'h3;
      hd_drv = 8'h00;
      repeat (4) tick();
      cs_n = 1'b0;
      repeat (4) tick();
      cs_n = 1'b1;
      repeat (3) begin
         tick();
         check(rdy_n, 16'h1);
      end
      check(rdy_oe_n, 16'h0);
      check(data_oe_n, 16'h1);
      tick();
      check(rdy_oe_n, 16'h1);
      check(addr, 16'h4037);
      repeat (8) tick();
   endtask
   initial begin
      resetn = 1'b0;
      cs_n = 1'b1;
      rnw = 1'b1;
      sel = 2'h0;
      hd_drv = 8'h00;
      repeat (6) tick();
      resetn = 1'b1;
      check(addr, 16'h0);
      check(rdy_oe_n, 16'h1);
      check(data_oe_n, 16'h1);
      t_addr();
      t_data();
      t_inc();
      t_hold();
      t_other();
      t_hard();
      t_abort();
      conclude();
   end
endmodule
